// File: dtc_top.sv
// dual 16-bit timer/counter with avalon-mm register slave
`timescale 1ns/1ps
module dtc_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // external pins
    input wire logic count_input_zero,
    input wire logic count_input_one,
    input wire logic gate_pin_zero,
    input wire logic gate_pin_one,
    // interrupt service acknowledges
    input wire logic service_ack_zero,
    input wire logic service_ack_one,
    // status outputs
    output dtc_pkg::dtc_count_s count_zero,
    output dtc_pkg::dtc_count_s count_one,
    output logic irq
);
    import dtc_pkg::*;

    // ------------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------------------
    // machine cycle divider
    // ------------------------------------------------------------------------
    localparam logic [3:0] DIV_LAST = 4'(CLOCKS_PER_MACHINE_CYCLE - 1);
    logic [3:0] div_cnt;
    logic mc_tick;
    assign mc_tick = (div_cnt == DIV_LAST);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 4'h0;
        end else if (mc_tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------------------
    // count input sampling, one sample per machine cycle
    // ------------------------------------------------------------------------
    logic [1:0] pin_now;
    logic [1:0] pin_prev;
    logic [1:0] fall_seen;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_now <= 2'b11;
            pin_prev <= 2'b11;
        end else if (mc_tick) begin
            pin_now <= {count_input_one, count_input_zero};
            pin_prev <= pin_now;
        end
    end
    // high in one sample, low in the next: spans two machine cycles
    assign fall_seen = pin_prev & ~pin_now;

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [7:0] timer_mode_config;
    logic [7:0] timer_run_and_flags;
    logic [7:0] irq_enable;
    dtc_unit_cfg_s cfg_zero;
    dtc_unit_cfg_s cfg_one;
    assign cfg_zero = dtc_unit_cfg_s'(timer_mode_config[3:0]);
    assign cfg_one = dtc_unit_cfg_s'(timer_mode_config[7:MODE_NIBBLE_ONE]);

    logic run_bit_unit_zero;
    logic run_bit_unit_one;
    assign run_bit_unit_zero = timer_run_and_flags[CTRL_RUN_ZERO];
    assign run_bit_unit_one = timer_run_and_flags[CTRL_RUN_ONE];

    logic wr;
    assign wr = avs_write;

    // ------------------------------------------------------------------------
    // read wait state: registered read data must stand when waitrequest drops
    // ------------------------------------------------------------------------
    logic rd_done;
    assign avs_waitrequest = avs_read && !rd_done;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_done <= 1'b0;
        end else begin
            rd_done <= avs_read && !rd_done;
        end
    end

    // ------------------------------------------------------------------------
    // count enable per unit
    // ------------------------------------------------------------------------
    function automatic logic step_of(input dtc_unit_cfg_s cfg, input logic run, input logic gate_pin,
                                     input logic fall);
        logic src;
        src = cfg.edge_sel ? fall : 1'b1;
        return mc_tick && run && (!cfg.gate || gate_pin) && src;
    endfunction

    logic step_zero;
    logic step_one;
    logic step_split_high;
    logic split;
    assign split = (cfg_zero.mode == DTC_MODE_SPLIT);
    assign step_zero = step_of(cfg_zero, run_bit_unit_zero, gate_pin_zero, fall_seen[0]);
    assign step_one = (cfg_one.mode != DTC_MODE_SPLIT) &&
                      step_of(cfg_one, run_bit_unit_one, gate_pin_one, fall_seen[1]);
    // split high byte: unit one's run bit, machine-cycle timing
    assign step_split_high = split && mc_tick && run_bit_unit_one;

    // ------------------------------------------------------------------------
    // counting step for one unit: returns next count and overflow
    // ------------------------------------------------------------------------
    function automatic logic [16:0] advance(input dtc_count_s c, input dtc_mode_e m);
        logic [8:0] lo;
        logic [16:0] res;
        res = {1'b0, c};
        lo = {1'b0, c.low} + 9'h001;
        case (m)
            DTC_MODE_13BIT: begin
                if (c.low[MODE0_LOW_BITS-1:0] == MODE0_LOW_MASK[MODE0_LOW_BITS-1:0]) begin
                    res = {(c.high == 8'hff), c.high + 8'h01, 8'h00};
                end else begin
                    res = {1'b0, c.high, (c.low & MODE0_LOW_MASK) + 8'h01};
                end
            end
            DTC_MODE_16BIT: res = {1'b0, c} + 17'h0_0001;
            DTC_MODE_RELOAD: res = lo[8] ? {1'b1, c.high, c.high} : {1'b0, c.high, lo[7:0]};
            DTC_MODE_SPLIT: res = {lo[8], c.high, lo[7:0]};
            default: res = {1'b0, c};
        endcase
        return res;
    endfunction

    logic [16:0] adv_zero;
    logic [16:0] adv_one;
    logic [8:0] adv_split_high;
    assign adv_zero = advance(count_zero, cfg_zero.mode);
    assign adv_one = advance(count_one, cfg_one.mode);
    assign adv_split_high = {1'b0, count_zero.high} + 9'h001;

    logic ovf_zero;
    logic ovf_one;
    assign ovf_zero = step_zero && adv_zero[16];
    assign ovf_one = (step_one && adv_one[16]) || (step_split_high && adv_split_high[8]);

    // ------------------------------------------------------------------------
    // count registers, unit zero
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_zero <= {COUNT_RESET, COUNT_RESET};
        end else begin
            if (wr && avs_address == ADDR_CNT_LOW_ZERO) begin
                count_zero.low <= avs_writedata[7:0];
            end else if (step_zero) begin
                count_zero.low <= adv_zero[7:0];
            end
            if (wr && avs_address == ADDR_CNT_HIGH_ZERO) begin
                count_zero.high <= avs_writedata[7:0];
            end else if (step_split_high) begin
                count_zero.high <= adv_split_high[7:0];
            end else if (step_zero && !split) begin
                count_zero.high <= adv_zero[15:8];
            end
        end
    end

    // ------------------------------------------------------------------------
    // count registers, unit one
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_one <= {COUNT_RESET, COUNT_RESET};
        end else begin
            if (wr && avs_address == ADDR_CNT_LOW_ONE) begin
                count_one.low <= avs_writedata[7:0];
            end else if (step_one) begin
                count_one.low <= adv_one[7:0];
            end
            if (wr && avs_address == ADDR_CNT_HIGH_ONE) begin
                count_one.high <= avs_writedata[7:0];
            end else if (step_one) begin
                count_one.high <= adv_one[15:8];
            end
        end
    end

    // ------------------------------------------------------------------------
    // mode and control registers; overflow flags set wins over clear
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_mode_config <= MODE_RESET;
        end else if (wr && avs_address == ADDR_MODE) begin
            timer_mode_config <= avs_writedata[7:0];
        end
    end

    logic [7:0] next_ctrl;
    always_comb begin
        next_ctrl = timer_run_and_flags;
        if (wr && avs_address == ADDR_CTRL) begin
            next_ctrl = avs_writedata[7:0];
        end
        if (service_ack_zero) begin
            next_ctrl[CTRL_FLAG_ZERO] = 1'b0;
        end
        if (service_ack_one) begin
            next_ctrl[CTRL_FLAG_ONE] = 1'b0;
        end
        if (ovf_zero) begin
            next_ctrl[CTRL_FLAG_ZERO] = 1'b1;
        end
        if (ovf_one) begin
            next_ctrl[CTRL_FLAG_ONE] = 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_run_and_flags <= CTRL_RESET;
        end else begin
            timer_run_and_flags <= next_ctrl;
        end
    end

    // ------------------------------------------------------------------------
    // interrupt status: bit 0 unit zero overflow, bit 1 unit one overflow
    // ------------------------------------------------------------------------
    logic [1:0] irq_status;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= 2'b00;
            irq_enable <= 8'h00;
        end else begin
            if (wr && avs_address == ADDR_IRQ_ENABLE) begin
                irq_enable <= {6'h00, avs_writedata[1:0]};
            end
            irq_status <= (irq_status & ~((wr && avs_address == ADDR_IRQ_CLEAR) ? avs_writedata[1:0] : 2'b00))
                          | {ovf_one, ovf_zero};
        end
    end
    assign irq = |(irq_status & irq_enable[1:0]);

    // ------------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !rd_done) begin
            case (avs_address)
                ADDR_MODE: avs_readdata <= {24'h00_0000, timer_mode_config};
                ADDR_CTRL: avs_readdata <= {24'h00_0000, timer_run_and_flags};
                ADDR_CNT_LOW_ZERO: avs_readdata <= {24'h00_0000, count_zero.low};
                ADDR_CNT_HIGH_ZERO: avs_readdata <= {24'h00_0000, count_zero.high};
                ADDR_CNT_LOW_ONE: avs_readdata <= {24'h00_0000, count_one.low};
                ADDR_CNT_HIGH_ONE: avs_readdata <= {24'h00_0000, count_one.high};
                ADDR_IRQ_STATUS: avs_readdata <= {30'h0000_0000, irq_status};
                ADDR_IRQ_ENABLE: avs_readdata <= {24'h00_0000, irq_enable};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_tick_period: assert property (mc_tick |=> !mc_tick [*8]) else $error("machine tick too early");
    // split high byte runs under unit one's run bit, so it is left out here
    a_run_halt: assert property (!run_bit_unit_zero && !(split && run_bit_unit_one)
        && !(wr && avs_address[3:1] == 3'b001)
        |=> $stable(count_zero)) else $error("halted unit zero moved");
    a_mode0_top_zero: assert property (cfg_zero.mode == DTC_MODE_13BIT && step_zero && !wr
        |=> count_zero.low[7:5] == 3'b000) else $error("mode 0 top bits set");
    a_reload_copy: assert property (cfg_zero.mode == DTC_MODE_RELOAD && step_zero && count_zero.low == 8'hff && !wr
        |=> count_zero.low == $past(count_zero.high)) else $error("reload missed");
    a_flag_set: assert property (ovf_zero |=> timer_run_and_flags[CTRL_FLAG_ZERO])
        else $error("overflow flag not set");
    a_one_stopped: assert property (cfg_one.mode == DTC_MODE_SPLIT && !wr |=> $stable(count_one))
        else $error("unit one moved in mode 3");
    a_gate_block: assert property (cfg_zero.gate && !gate_pin_zero |-> !step_zero)
        else $error("gated unit counted");
    a_edge_only: assert property (cfg_zero.edge_sel && step_zero |-> $past(pin_now[0], 12) && !pin_now[0])
        else $error("count without falling edge");
    a_wrap16: assert property (cfg_zero.mode == DTC_MODE_16BIT && step_zero && count_zero == 16'hffff && !wr
        |=> count_zero == 16'h0000) else $error("16-bit wrap wrong");
    a_irq_level: assert property (ovf_zero && irq_enable[0] && !wr |=> irq)
        else $error("enabled overflow gave no irq");
    a_tick_spacing: assert property (mc_tick |-> ##12 mc_tick)
        else $error("machine tick spacing wrong");
    a_run_halt_one: assert property (!run_bit_unit_one && !(wr && avs_address[3:1] == 3'b010)
        |=> $stable(count_one)) else $error("halted unit one moved");
    a_split_high: assert property (split && !run_bit_unit_one && !(wr && avs_address == ADDR_CNT_HIGH_ZERO)
        |=> $stable(count_zero.high)) else $error("split high byte moved without run");
    a_split_flag: assert property (step_split_high && count_zero.high == 8'hff
        |=> timer_run_and_flags[CTRL_FLAG_ONE]) else $error("split high overflow lost");
    a_flag_one_set: assert property (ovf_one |=> timer_run_and_flags[CTRL_FLAG_ONE])
        else $error("overflow flag one not set");
    a_ack_clear: assert property (service_ack_zero && !ovf_zero |=> !timer_run_and_flags[CTRL_FLAG_ZERO])
        else $error("service did not clear flag zero");
    a_gate_block_one: assert property (cfg_one.gate && !gate_pin_one |-> !step_one)
        else $error("gated unit one counted");
    a_edge_only_one: assert property (cfg_one.edge_sel && step_one |-> $past(pin_now[1], 12) && !pin_now[1])
        else $error("unit one count without falling edge");
    a_wrap13: assert property (cfg_zero.mode == DTC_MODE_13BIT && step_zero && count_zero == 16'hff1f && !wr
        |=> count_zero == 16'h0000) else $error("13-bit wrap wrong");
    a_wr_load_low: assert property (wr && avs_address == ADDR_CNT_LOW_ZERO
        |=> count_zero.low == $past(avs_writedata[7:0])) else $error("low byte write lost");
    a_wr_load_high: assert property (wr && avs_address == ADDR_CNT_HIGH_ONE
        |=> count_one.high == $past(avs_writedata[7:0])) else $error("high byte write lost");
    a_read_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read wait state too long");
    a_read_stand: assert property (avs_read && !avs_waitrequest |=> $stable(avs_readdata))
        else $error("read data did not stand");

    c_overflow_zero: cover property (ovf_zero);
    c_split_high: cover property (step_split_high);
    c_edge_count: cover property (cfg_one.edge_sel && step_one);
    c_irq: cover property (irq);
    c_read_wait: cover property (avs_read && avs_waitrequest);
endmodule // dtc_top

// File: dtc_pkg.sv
// package for the dual timer/counter: register map, field layout, types
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package dtc_pkg;
    // register word addresses (consecutive, one per 32-bit word)
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h1;
    localparam logic [3:0] ADDR_CNT_LOW_ZERO = 4'h2;
    localparam logic [3:0] ADDR_CNT_HIGH_ZERO = 4'h3;
    localparam logic [3:0] ADDR_CNT_LOW_ONE = 4'h4;
    localparam logic [3:0] ADDR_CNT_HIGH_ONE = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h7;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h8;
    // control register bit positions
    localparam int CTRL_FLAG_ONE = 7;
    localparam int CTRL_RUN_ONE = 6;
    localparam int CTRL_FLAG_ZERO = 5;
    localparam int CTRL_RUN_ZERO = 4;
    // mode register: unit zero in low nibble, unit one in high nibble
    localparam int MODE_NIBBLE_ONE = 4;
    localparam int MODE_GATE = 3;
    localparam int MODE_SEL = 2;
    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    // timing
    localparam int CLOCKS_PER_MACHINE_CYCLE = 12;
    localparam int MODE0_LOW_BITS = 5;
    localparam logic [7:0] MODE0_LOW_MASK = 8'h1f;

    typedef enum logic [1:0] {
        DTC_MODE_13BIT = 2'b00,
        DTC_MODE_16BIT = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_e;

    typedef struct packed {
        logic gate;
        logic edge_sel;
        dtc_mode_e mode;
    } dtc_unit_cfg_s;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dtc_count_s;
endpackage

// File: dtc_pins.sv
// partner model: external count inputs and gate pins of the dual timer/counter
`timescale 1ns/1ps
module dtc_pins (
    // clock
    input wire logic sys_clk,
    // pins toward the timer block
    output logic count_input_zero,
    output logic count_input_one,
    output logic gate_pin_zero,
    output logic gate_pin_one
);
    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    initial begin
        count_input_zero = 1'b1;
        count_input_one = 1'b1;
        gate_pin_zero = 1'b0;
        gate_pin_one = 1'b0;
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    task automatic set_count(input int unit, input logic v);
        if (unit == 0) begin
            count_input_zero <= v;
        end else begin
            count_input_one <= v;
        end
    endtask

    task automatic set_gate(input int unit, input logic v);
        if (unit == 0) begin
            gate_pin_zero <= v;
        end else begin
            gate_pin_one <= v;
        end
    endtask

    // k falling edges, each level held for hold clocks
    task automatic pulses(input int unit, input int k, input int hold);
        for (int i = 0; i < k; i++) begin
            set_count(unit, 1'b0);
            repeat (hold) @(posedge sys_clk);
            set_count(unit, 1'b1);
            repeat (hold) @(posedge sys_clk);
        end
    endtask
endmodule // dtc_pins

// File: tb_top.sv
// self-checking testbench for the dual timer/counter
`timescale 1ns/1ps
module tb_top;
    import dtc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic count_input_zero, count_input_one, gate_pin_zero, gate_pin_one;
    logic service_ack_zero = 1'b0;
    logic service_ack_one = 1'b0;
    dtc_count_s count_zero, count_one;
    logic irq;
    int n_checks = 0;
    int n_mismatch = 0;

    always #50 sys_clk = ~sys_clk;

    dtc_pins pins_u (.sys_clk(sys_clk), .count_input_zero(count_input_zero), .count_input_one(count_input_one),
        .gate_pin_zero(gate_pin_zero), .gate_pin_one(gate_pin_one));

    dtc_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .count_input_zero(count_input_zero),
        .count_input_one(count_input_one), .gate_pin_zero(gate_pin_zero), .gate_pin_one(gate_pin_one),
        .service_ack_zero(service_ack_zero), .service_ack_one(service_ack_one),
        .count_zero(count_zero), .count_one(count_one), .irq(irq));

    // ------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    // read data taken at the edge where waitrequest is sampled low
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata[7:0];
        avs_read <= 1'b0;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic prep(input logic [7:0] m, input logic [7:0] l0, h0, l1, h1);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MODE, m);
        wr(ADDR_CNT_LOW_ZERO, l0);
        wr(ADDR_CNT_HIGH_ZERO, h0);
        wr(ADDR_CNT_LOW_ONE, l1);
        wr(ADDR_CNT_HIGH_ONE, h1);
        wr(ADDR_IRQ_CLEAR, 8'h03);
    endtask

    // control value c held for exactly 12*n clocks; control read just before stop
    task automatic run_for(input logic [7:0] c, input int n, output logic [7:0] f);
        wr(ADDR_CTRL, c);
        repeat (12 * n - 5) @(posedge sys_clk);
        rd(ADDR_CTRL, f);
        wr(ADDR_CTRL, 8'h00);
    endtask

    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd(a + 4'h1, v[15:8]);
        rd(a, v[7:0]);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        conclude();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [7:0] v;
        logic [7:0] f;
        logic [15:0] c;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int a = 0; a < 8; a++) begin
            rd(a[3:0], v);
            chk("reset register", 16'h0000, {8'h00, v});
        end
        wr(4'hf, 8'hff);
        rd(4'hf, v);
        chk("unmapped read", 16'h0000, {8'h00, v});
        $display("test reset done");

        prep(8'h10, 8'h00, 8'h00, 8'h00, 8'h00);
        run_for(8'h40, 5, f);
        rd16(ADDR_CNT_LOW_ONE, c);
        chk("unit one timer", 16'h0005, c);
        chk("unit zero idle", 16'h0000, count_zero);
        repeat (36) @(posedge sys_clk);
        chk("frozen count", 16'h0005, count_one);
        $display("test timer done");

        prep(8'h01, 8'hff, 8'hff, 8'h00, 8'h00);
        run_for(8'h10, 2, f);
        rd16(ADDR_CNT_LOW_ZERO, c);
        chk("mode 1 wrap", 16'h0001, c);
        chk("flag zero", 16'h0001, {15'h0000, f[5]});
        rd(ADDR_IRQ_STATUS, v);
        chk("irq status", 16'h0001, {8'h00, v});
        chk("irq masked", 16'h0000, {15'h0000, irq});
        wr(ADDR_IRQ_ENABLE, 8'h01);
        @(posedge sys_clk);
        chk("irq enabled", 16'h0001, {15'h0000, irq});
        wr(ADDR_IRQ_CLEAR, 8'h01);
        @(posedge sys_clk);
        chk("irq cleared", 16'h0000, {15'h0000, irq});
        rd(ADDR_IRQ_STATUS, v);
        chk("status cleared", 16'h0000, {8'h00, v});
        wr(ADDR_IRQ_ENABLE, 8'h00);
        $display("test overflow done");

        prep(8'h00, 8'h1f, 8'hff, 8'h00, 8'h00);
        run_for(8'h10, 2, f);
        rd16(ADDR_CNT_LOW_ZERO, c);
        chk("mode 0 wrap", 16'h0001, c);
        chk("mode 0 flag", 16'h0001, {15'h0000, f[5]});
        prep(8'h02, 8'hfe, 8'hf0, 8'h00, 8'h00);
        run_for(8'h10, 3, f);
        rd16(ADDR_CNT_LOW_ZERO, c);
        chk("mode 2 reload", 16'hf0f1, c);
        $display("test modes done");

        prep(8'h33, 8'h10, 8'hff, 8'h34, 8'h12);
        run_for(8'h50, 2, f);
        rd16(ADDR_CNT_LOW_ZERO, c);
        chk("split bytes", 16'h0112, c);
        chk("split flags", 16'h0002, {14'h0000, f[7], f[5]});
        rd16(ADDR_CNT_LOW_ONE, c);
        chk("unit one stopped", 16'h1234, c);
        $display("test split done");

        pins_u.set_gate(0, 1'b0);
        prep(8'h09, 8'h00, 8'h00, 8'h00, 8'h00);
        run_for(8'h10, 4, f);
        rd16(ADDR_CNT_LOW_ZERO, c);
        chk("gate closed", 16'h0000, c);
        pins_u.set_gate(0, 1'b1);
        repeat (30) @(posedge sys_clk);
        run_for(8'h10, 4, f);
        rd16(ADDR_CNT_LOW_ZERO, c);
        chk("gate open", 16'h0004, c);
        $display("test gate done");

        prep(8'h55, 8'h00, 8'h00, 8'h00, 8'h00);
        wr(ADDR_CTRL, 8'h50);
        fork
            pins_u.pulses(0, 5, 24);
            pins_u.pulses(1, 3, 24);
        join
        repeat (48) @(posedge sys_clk);
        rd(ADDR_CNT_LOW_ZERO, v);
        chk("edges zero", 16'h0005, {8'h00, v});
        rd(ADDR_CNT_LOW_ONE, v);
        chk("edges one", 16'h0003, {8'h00, v});
        $display("test counter done");

        wr(ADDR_CTRL, 8'ha0);
        service_ack_zero <= 1'b1;
        @(posedge sys_clk);
        service_ack_zero <= 1'b0;
        rd(ADDR_CTRL, v);
        chk("ack zero", 16'h0080, {8'h00, v});
        service_ack_one <= 1'b1;
        @(posedge sys_clk);
        service_ack_one <= 1'b0;
        rd(ADDR_CTRL, v);
        chk("ack one", 16'h0000, {8'h00, v});
        $display("test service done");
        conclude();
    end
endmodule // tb_top
